/* File: src/ol_startup_pkg.sv */
// constants, field layout and lookup tables for the open-loop start-up register
package ol_startup_pkg;

	localparam int REG_W = 32;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// bits 5:0 belong to other logic and always read back as zero here
	localparam logic [31:0] REG_KEEP_MASK = 32'hffff_ffc0;

	localparam int PARITY_BIT = 31;
	localparam int LIMIT_SRC_BIT = 30;
	localparam int DUTY_MSB = 29;
	localparam int DUTY_LSB = 27;
	localparam int LIMIT_MSB = 26;
	localparam int LIMIT_LSB = 23;
	localparam int ACC1_MSB = 22;
	localparam int ACC1_LSB = 18;
	localparam int ACC2_MSB = 17;
	localparam int ACC2_LSB = 13;
	localparam int HANDOFF_MSB = 12;
	localparam int HANDOFF_LSB = 8;
	localparam int AUTO_HANDOFF_BIT = 7;
	localparam int FIRST_CYC_BIT = 6;

	localparam int DUTY_W = 7;
	localparam int ACC_W = 25;
	localparam int HZ_W = 10;

	localparam logic [3:0] LIMIT_NA_CODE = 4'h0;
	localparam logic [3:0] FIRST_CYC_ZERO_CODE = 4'h0;

	// duty ceiling in whole percent
	function automatic logic [DUTY_W-1:0] duty_lut(input logic [2:0] code);
		case (code)
			3'h0: duty_lut = 7'd10;
			3'h1: duty_lut = 7'd15;
			3'h2: duty_lut = 7'd20;
			3'h3: duty_lut = 7'd25;
			3'h4: duty_lut = 7'd30;
			3'h5: duty_lut = 7'd40;
			3'h6: duty_lut = 7'd50;
			default: duty_lut = 7'd100;
		endcase
	endfunction : duty_lut

	// rate in thousandths of a unit, shared by both acceleration terms
	function automatic logic [ACC_W-1:0] accel_lut(input logic [4:0] code);
		case (code)
			5'h00: accel_lut = 25'd5;
			5'h01: accel_lut = 25'd10;
			5'h02: accel_lut = 25'd25;
			5'h03: accel_lut = 25'd50;
			5'h04: accel_lut = 25'd100;
			5'h05: accel_lut = 25'd250;
			5'h06: accel_lut = 25'd500;
			5'h07: accel_lut = 25'd1000;
			5'h08: accel_lut = 25'd2500;
			5'h09: accel_lut = 25'd5000;
			5'h0a: accel_lut = 25'd7500;
			5'h0b: accel_lut = 25'd10000;
			5'h0c: accel_lut = 25'd12500;
			5'h0d: accel_lut = 25'd15000;
			5'h0e: accel_lut = 25'd20000;
			5'h0f: accel_lut = 25'd30000;
			5'h10: accel_lut = 25'd40000;
			5'h11: accel_lut = 25'd50000;
			5'h12: accel_lut = 25'd60000;
			5'h13: accel_lut = 25'd75000;
			5'h14: accel_lut = 25'd100000;
			5'h15: accel_lut = 25'd125000;
			5'h16: accel_lut = 25'd150000;
			5'h17: accel_lut = 25'd175000;
			5'h18: accel_lut = 25'd200000;
			5'h19: accel_lut = 25'd250000;
			5'h1a: accel_lut = 25'd300000;
			5'h1b: accel_lut = 25'd400000;
			5'h1c: accel_lut = 25'd500000;
			5'h1d: accel_lut = 25'd750000;
			5'h1e: accel_lut = 25'd1000000;
			default: accel_lut = 25'd32767000;
		endcase
	endfunction : accel_lut

	// handoff frequency in hertz; code 0 has no defined value and gives 0
	function automatic logic [HZ_W-1:0] handoff_lut(input logic [4:0] code);
		case (code)
			5'h00: handoff_lut = 10'd0;
			5'h01: handoff_lut = 10'd4;
			5'h02: handoff_lut = 10'd8;
			5'h03: handoff_lut = 10'd12;
			5'h04: handoff_lut = 10'd16;
			5'h05: handoff_lut = 10'd20;
			5'h06: handoff_lut = 10'd24;
			5'h07: handoff_lut = 10'd28;
			5'h08: handoff_lut = 10'd32;
			5'h09: handoff_lut = 10'd36;
			5'h0a: handoff_lut = 10'd40;
			5'h0b: handoff_lut = 10'd45;
			5'h0c: handoff_lut = 10'd50;
			5'h0d: handoff_lut = 10'd55;
			5'h0e: handoff_lut = 10'd60;
			5'h0f: handoff_lut = 10'd65;
			5'h10: handoff_lut = 10'd70;
			5'h11: handoff_lut = 10'd75;
			5'h12: handoff_lut = 10'd80;
			5'h13: handoff_lut = 10'd85;
			5'h14: handoff_lut = 10'd90;
			5'h15: handoff_lut = 10'd100;
			5'h16: handoff_lut = 10'd150;
			5'h17: handoff_lut = 10'd200;
			5'h18: handoff_lut = 10'd250;
			5'h19: handoff_lut = 10'd300;
			5'h1a: handoff_lut = 10'd350;
			5'h1b: handoff_lut = 10'd400;
			5'h1c: handoff_lut = 10'd450;
			5'h1d: handoff_lut = 10'd500;
			5'h1e: handoff_lut = 10'd550;
			default: handoff_lut = 10'd600;
		endcase
	endfunction : handoff_lut

endpackage : ol_startup_pkg

/* File: src/open_loop_startup_config.sv */
// open-loop start-up configuration register with decoded outputs
// Functional notes
// - bit 30 picks dedicated open-loop limit (0) or general current limit (1)
// - bits 29-27 cap open-loop duty: 10,15,20,25,30,40,50,100 percent
// - bits 26-23 open-loop limit, 0.1 V steps, code 0 not applicable
// - bits 22-18 first acceleration, 0.005 to 1000 Hz/s, top code unlimited
// - bits 17-13 second acceleration, same scale in Hz/s2, top code unlimited
// - bits 12-8 handoff frequency, 4 Hz up to 600 Hz
// - bit 7 set lets the device choose the handoff point itself
// - bit 6 set forces first-cycle frequency to 0 Hz, else setting used
`timescale 1ns/1ps
`default_nettype none
module open_loop_startup_config
	import ol_startup_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_wr_en,
	input wire logic [REG_W-1:0] i_wr_data,
	input wire logic [3:0] i_general_current_limit,
	input wire logic [3:0] i_initial_cycle_freq_setting,
	output logic [REG_W-1:0] o_rd_data,
	output logic o_parity,
	output logic [DUTY_W-1:0] o_ceiling_a_pct,
	output logic [3:0] o_ol_current_threshold,
	output logic o_ol_current_threshold_valid,
	output logic [ACC_W-1:0] o_ol_accel_first_milli,
	output logic o_ol_accel_first_unlimited,
	output logic [ACC_W-1:0] o_ol_accel_second_milli,
	output logic o_ol_accel_second_unlimited,
	output logic [HZ_W-1:0] o_handoff_freq_hz,
	output logic o_handoff_auto,
	output logic [3:0] o_initial_cycle_freq_code,
	output logic o_initial_cycle_zero_hz
);

	////////////////////////////////////////////////////////////////////////////
	// register storage

	logic [REG_W-1:0] cfg_ff;
	logic [REG_W-1:0] nxt_cfg;

	always_comb begin
		nxt_cfg = cfg_ff;
		if (i_wr_en) begin
			nxt_cfg = i_wr_data & REG_KEEP_MASK;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_ff <= REG_RESET;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// field decode

	startup_field_if fld ();

	assign fld.duty_code = cfg_ff[DUTY_MSB:DUTY_LSB];
	assign fld.acc1_code = cfg_ff[ACC1_MSB:ACC1_LSB];
	assign fld.acc2_code = cfg_ff[ACC2_MSB:ACC2_LSB];
	assign fld.handoff_code = cfg_ff[HANDOFF_MSB:HANDOFF_LSB];

	startup_field_decode u_decode (
		.fld (fld.dec)
	);

	////////////////////////////////////////////////////////////////////////////
	// registered outputs; decoded values lag the stored word by one cycle

	logic [REG_W-1:0] rd_ff;
	logic [REG_W-1:0] nxt_rd;
	logic parity_ff;
	logic nxt_parity;
	logic [DUTY_W-1:0] duty_ff;
	logic [DUTY_W-1:0] nxt_duty;
	logic [3:0] limit_ff;
	logic [3:0] nxt_limit;
	logic limit_ok_ff;
	logic nxt_limit_ok;
	logic [ACC_W-1:0] acc1_ff;
	logic [ACC_W-1:0] nxt_acc1;
	logic acc1_inf_ff;
	logic nxt_acc1_inf;
	logic [ACC_W-1:0] acc2_ff;
	logic [ACC_W-1:0] nxt_acc2;
	logic acc2_inf_ff;
	logic nxt_acc2_inf;
	logic [HZ_W-1:0] handoff_ff;
	logic [HZ_W-1:0] nxt_handoff;
	logic auto_ff;
	logic nxt_auto;
	logic [3:0] first_ff;
	logic [3:0] nxt_first;
	logic zero_ff;
	logic nxt_zero;

	// top code of either acceleration field means no limit
	function automatic logic is_unlimited(input logic [4:0] code);
		is_unlimited = &code;
	endfunction : is_unlimited

	////////////////////////////////////////////////////////////////////////////
	// readback group: raw word and parity bit

	always_comb begin
		nxt_rd = cfg_ff;
		// parity is only carried; checking it is left to the reader
		nxt_parity = cfg_ff[PARITY_BIT];
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rd_ff <= REG_RESET;
			parity_ff <= 1'b0;
		end else begin
			rd_ff <= nxt_rd;
			parity_ff <= nxt_parity;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// current limit group

	always_comb begin
		// general limit shares the 0.1 V scale, so one output serves both sources
		if (cfg_ff[LIMIT_SRC_BIT]) begin
			nxt_limit = i_general_current_limit;
		end else begin
			nxt_limit = cfg_ff[LIMIT_MSB:LIMIT_LSB];
		end
		nxt_limit_ok = (nxt_limit != LIMIT_NA_CODE);
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			limit_ff <= 4'h0;
			limit_ok_ff <= 1'b0;
		end else begin
			limit_ff <= nxt_limit;
			limit_ok_ff <= nxt_limit_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// table group: duty ceiling, acceleration and handoff values

	always_comb begin
		nxt_duty = fld.duty_pct;
		nxt_acc1 = fld.acc1_milli;
		nxt_acc1_inf = is_unlimited(fld.acc1_code);
		nxt_acc2 = fld.acc2_milli;
		nxt_acc2_inf = is_unlimited(fld.acc2_code);
		nxt_handoff = fld.handoff_hz;
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			duty_ff <= '0;
			acc1_ff <= '0;
			acc1_inf_ff <= 1'b0;
			acc2_ff <= '0;
			acc2_inf_ff <= 1'b0;
			handoff_ff <= '0;
		end else begin
			duty_ff <= nxt_duty;
			acc1_ff <= nxt_acc1;
			acc1_inf_ff <= nxt_acc1_inf;
			acc2_ff <= nxt_acc2;
			acc2_inf_ff <= nxt_acc2_inf;
			handoff_ff <= nxt_handoff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flag group: handoff mode and first-cycle source

	always_comb begin
		// threshold still shown when auto is on; the sequencer ignores it then
		nxt_auto = cfg_ff[AUTO_HANDOFF_BIT];
		nxt_zero = cfg_ff[FIRST_CYC_BIT];
		if (cfg_ff[FIRST_CYC_BIT]) begin
			nxt_first = FIRST_CYC_ZERO_CODE;
		end else begin
			nxt_first = i_initial_cycle_freq_setting;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			auto_ff <= 1'b0;
			first_ff <= 4'h0;
			zero_ff <= 1'b0;
		end else begin
			auto_ff <= nxt_auto;
			first_ff <= nxt_first;
			zero_ff <= nxt_zero;
		end
	end

	assign o_rd_data = rd_ff;
	assign o_parity = parity_ff;
	assign o_ceiling_a_pct = duty_ff;
	assign o_ol_current_threshold = limit_ff;
	assign o_ol_current_threshold_valid = limit_ok_ff;
	assign o_ol_accel_first_milli = acc1_ff;
	assign o_ol_accel_first_unlimited = acc1_inf_ff;
	assign o_ol_accel_second_milli = acc2_ff;
	assign o_ol_accel_second_unlimited = acc2_inf_ff;
	assign o_handoff_freq_hz = handoff_ff;
	assign o_handoff_auto = auto_ff;
	assign o_initial_cycle_freq_code = first_ff;
	assign o_initial_cycle_zero_hz = zero_ff;

endmodule : open_loop_startup_config
`default_nettype wire

/* File: src/startup_field_decode.sv */
// table decode of the start-up field codes
`timescale 1ns/1ps
`default_nettype none
module startup_field_decode
	import ol_startup_pkg::*;
(
	startup_field_if.dec fld
);
	always_comb begin
		fld.duty_pct = duty_lut(fld.duty_code);
		fld.acc1_milli = accel_lut(fld.acc1_code);
		fld.acc2_milli = accel_lut(fld.acc2_code);
		fld.handoff_hz = handoff_lut(fld.handoff_code);
	end
endmodule : startup_field_decode
`default_nettype wire

/* File: src/startup_field_if.sv */
// field codes out to the decoder and decoded values back
`timescale 1ns/1ps
`default_nettype none
interface startup_field_if;
	import ol_startup_pkg::*;
	logic [2:0] duty_code;
	logic [4:0] acc1_code;
	logic [4:0] acc2_code;
	logic [4:0] handoff_code;
	logic [DUTY_W-1:0] duty_pct;
	logic [ACC_W-1:0] acc1_milli;
	logic [ACC_W-1:0] acc2_milli;
	logic [HZ_W-1:0] handoff_hz;
	modport regs (output duty_code, acc1_code, acc2_code, handoff_code,
		input duty_pct, acc1_milli, acc2_milli, handoff_hz);
	modport dec (input duty_code, acc1_code, acc2_code, handoff_code,
		output duty_pct, acc1_milli, acc2_milli, handoff_hz);
endinterface : startup_field_if
`default_nettype wire

/* File: test/ol_startup_checker.sv */
// assertions on the ports of the open-loop start-up register
`timescale 1ns/1ps
`default_nettype none
module ol_startup_checker
	import ol_startup_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_wr_en,
	input wire logic [REG_W-1:0] i_wr_data,
	input wire logic [3:0] i_general_current_limit,
	input wire logic [3:0] i_initial_cycle_freq_setting,
	input wire logic [REG_W-1:0] o_rd_data,
	input wire logic o_parity,
	input wire logic [DUTY_W-1:0] o_ceiling_a_pct,
	input wire logic [3:0] o_ol_current_threshold,
	input wire logic o_ol_current_threshold_valid,
	input wire logic [ACC_W-1:0] o_ol_accel_first_milli,
	input wire logic o_ol_accel_first_unlimited,
	input wire logic [ACC_W-1:0] o_ol_accel_second_milli,
	input wire logic o_ol_accel_second_unlimited,
	input wire logic [HZ_W-1:0] o_handoff_freq_hz,
	input wire logic o_handoff_auto,
	input wire logic [3:0] o_initial_cycle_freq_code,
	input wire logic o_initial_cycle_zero_hz
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);
	////////////////////////////////////////////////////////////////////////////////
	// outputs lag the stored word by one edge, so skip the first edge after reset
	property p_store;
		$past(i_wr_en, 2) |-> o_rd_data == ($past(i_wr_data, 2) & REG_KEEP_MASK);
	endproperty
	a_store: assert property (p_store) else $error("stored word wrong");
	property p_hold;
		!$past(i_wr_en) && !$past(i_wr_en, 2) |-> $stable(o_rd_data) && o_parity == o_rd_data[31];
	endproperty
	a_hold: assert property (p_hold) else $error("word or parity moved");
	property p_duty;
		$past(i_reset_n) && o_rd_data[29:27] == 3'h7 |-> o_ceiling_a_pct == 7'd100;
	endproperty
	a_duty: assert property (p_duty) else $error("duty ceiling wrong");
	property p_limit;
		$past(i_reset_n) |-> o_ol_current_threshold == (o_rd_data[30] ?
			$past(i_general_current_limit) : o_rd_data[26:23])
			&& o_ol_current_threshold_valid == (o_ol_current_threshold != 4'h0);
	endproperty
	a_limit: assert property (p_limit) else $error("limit source wrong");
	property p_acc1;
		$past(i_reset_n) |-> o_ol_accel_first_unlimited == (o_rd_data[22:18] == 5'h1f);
	endproperty
	a_acc1: assert property (p_acc1) else $error("first accel flag wrong");
	property p_acc2;
		$past(i_reset_n) && o_rd_data[17:13] == 5'h00 |-> o_ol_accel_second_milli == 25'd5
			&& !o_ol_accel_second_unlimited;
	endproperty
	a_acc2: assert property (p_acc2) else $error("second accel wrong");
	property p_hoff;
		$past(i_reset_n) && o_rd_data[12:8] == 5'h1f |-> o_handoff_freq_hz == 10'd600;
	endproperty
	a_hoff: assert property (p_hoff) else $error("handoff freq wrong");
	property p_auto;
		$past(i_reset_n) |-> o_handoff_auto == o_rd_data[7];
	endproperty
	a_auto: assert property (p_auto) else $error("auto handoff wrong");
	property p_first;
		$past(i_reset_n) |-> o_initial_cycle_zero_hz == o_rd_data[6] && o_initial_cycle_freq_code
			== (o_rd_data[6] ? 4'h0 : $past(i_initial_cycle_freq_setting));
	endproperty
	a_first: assert property (p_first) else $error("first cycle wrong");
endmodule : ol_startup_checker
bind open_loop_startup_config ol_startup_checker u_chk (
	.i_sys_clk (i_sys_clk),
	.i_reset_n (i_reset_n),
	.i_wr_en (i_wr_en),
	.i_wr_data (i_wr_data),
	.i_general_current_limit (i_general_current_limit),
	.i_initial_cycle_freq_setting (i_initial_cycle_freq_setting),
	.o_rd_data (o_rd_data),
	.o_parity (o_parity),
	.o_ceiling_a_pct (o_ceiling_a_pct),
	.o_ol_current_threshold (o_ol_current_threshold),
	.o_ol_current_threshold_valid (o_ol_current_threshold_valid),
	.o_ol_accel_first_milli (o_ol_accel_first_milli),
	.o_ol_accel_first_unlimited (o_ol_accel_first_unlimited),
	.o_ol_accel_second_milli (o_ol_accel_second_milli),
	.o_ol_accel_second_unlimited (o_ol_accel_second_unlimited),
	.o_handoff_freq_hz (o_handoff_freq_hz),
	.o_handoff_auto (o_handoff_auto),
	.o_initial_cycle_freq_code (o_initial_cycle_freq_code),
	.o_initial_cycle_zero_hz (o_initial_cycle_zero_hz)
);
`default_nettype wire

/* File: test/test_open_loop_startup_config.sv */
// self-checking bench for the open-loop start-up register
`timescale 1ns/1ps
`default_nettype none
module test_open_loop_startup_config import ol_startup_pkg::*;;
	logic i_sys_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_wr_en = 1'b0;
	logic [31:0] i_wr_data = 32'h0000_0000;
	logic [3:0] i_general_current_limit = 4'h0;
	logic [3:0] i_initial_cycle_freq_setting = 4'h0;
	logic [31:0] o_rd_data;
	logic o_parity, o_ol_current_threshold_valid, o_ol_accel_first_unlimited;
	logic o_ol_accel_second_unlimited, o_handoff_auto, o_initial_cycle_zero_hz;
	logic [6:0] o_ceiling_a_pct;
	logic [3:0] o_ol_current_threshold, o_initial_cycle_freq_code;
	logic [24:0] o_ol_accel_first_milli, o_ol_accel_second_milli;
	logic [9:0] o_handoff_freq_hz;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;
	open_loop_startup_config u_dut (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_wr_en (i_wr_en),
		.i_wr_data (i_wr_data),
		.i_general_current_limit (i_general_current_limit),
		.i_initial_cycle_freq_setting (i_initial_cycle_freq_setting),
		.o_rd_data (o_rd_data),
		.o_parity (o_parity),
		.o_ceiling_a_pct (o_ceiling_a_pct),
		.o_ol_current_threshold (o_ol_current_threshold),
		.o_ol_current_threshold_valid (o_ol_current_threshold_valid),
		.o_ol_accel_first_milli (o_ol_accel_first_milli),
		.o_ol_accel_first_unlimited (o_ol_accel_first_unlimited),
		.o_ol_accel_second_milli (o_ol_accel_second_milli),
		.o_ol_accel_second_unlimited (o_ol_accel_second_unlimited),
		.o_handoff_freq_hz (o_handoff_freq_hz),
		.o_handoff_auto (o_handoff_auto),
		.o_initial_cycle_freq_code (o_initial_cycle_freq_code),
		.o_initial_cycle_zero_hz (o_initial_cycle_zero_hz)
	);
	initial forever #50 i_sys_clk = ~i_sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	// outputs settle one edge after the storing edge
	task automatic wr(input logic [31:0] w);
		@(negedge i_sys_clk);
		i_wr_en = 1'b1;
		i_wr_data = w;
		@(negedge i_sys_clk);
		i_wr_en = 1'b0;
		@(negedge i_sys_clk);
	endtask : wr
	task automatic t_duty();
		logic [6:0] pct [8] = '{7'd10, 7'd15, 7'd20, 7'd25, 7'd30, 7'd40, 7'd50, 7'd100};
		for (int c = 0; c < 8; c++) begin
			wr(32'(c) << 27);
			chk(o_ceiling_a_pct, pct[c]);
		end
		// back to back: the later word wins
		@(negedge i_sys_clk);
		i_wr_en = 1'b1;
		i_wr_data = 32'h0800_0000;
		@(negedge i_sys_clk);
		i_wr_data = 32'h3000_0000;
		@(negedge i_sys_clk);
		i_wr_en = 1'b0;
		@(negedge i_sys_clk);
		chk(o_ceiling_a_pct, 7'd50);
	endtask : t_duty
	task automatic t_limit();
		wr(32'h0780_0000);
		chk({o_ol_current_threshold_valid, o_ol_current_threshold}, 5'h1f);
		i_general_current_limit = 4'h9;
		wr(32'h4000_0000);
		chk({o_ol_current_threshold_valid, o_ol_current_threshold}, 5'h19);
		i_general_current_limit = 4'h0;
		@(negedge i_sys_clk);
		chk(o_ol_current_threshold_valid, 1'b0);
	endtask : t_limit
	task automatic t_accel();
		logic [4:0] code [3] = '{5'h00, 5'h1e, 5'h1f};
		logic [24:0] rate [3] = '{25'd5, 25'd1000000, 25'd32767000};
		for (int k = 0; k < 3; k++) begin
			wr((32'(code[k]) << 18) | (32'(code[k]) << 13));
			chk({o_ol_accel_first_unlimited, o_ol_accel_first_milli}, {k == 2, rate[k]});
			chk({o_ol_accel_second_unlimited, o_ol_accel_second_milli}, {k == 2, rate[k]});
		end
	endtask : t_accel
	task automatic t_handoff();
		logic [4:0] code [5] = '{5'h01, 5'h0b, 5'h15, 5'h16, 5'h1f};
		logic [9:0] hz [5] = '{10'd4, 10'd45, 10'd100, 10'd150, 10'd600};
		for (int k = 0; k < 5; k++) begin
			wr(32'(code[k]) << 8);
			chk(o_handoff_freq_hz, hz[k]);
		end
	endtask : t_handoff
	task automatic t_flags();
		i_initial_cycle_freq_setting = 4'ha;
		wr(32'h0000_0040);
		chk({o_handoff_auto, o_initial_cycle_zero_hz, o_initial_cycle_freq_code}, 6'h10);
		wr(32'h0000_0080);
		chk({o_handoff_auto, o_initial_cycle_zero_hz, o_initial_cycle_freq_code}, 6'h2a);
	endtask : t_flags
	task automatic t_readback();
		wr(32'hffff_ffff);
		chk(o_parity, 1'b1);
		chk(o_rd_data, 32'hffff_ffc0);
		@(negedge i_sys_clk);
		i_reset_n = 1'b0;
		@(negedge i_sys_clk);
		chk(o_rd_data, 32'h0000_0000);
		i_reset_n = 1'b1;
		@(negedge i_sys_clk);
		chk({o_ceiling_a_pct, o_ol_accel_first_milli}, {7'd10, 25'd5});
		// setting input from the flag scenario is still applied
		chk({o_initial_cycle_zero_hz, o_initial_cycle_freq_code}, 5'h0a);
	endtask : t_readback
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	// a hang is cut short well past the fewer than a hundred cycles the run needs
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (5) @(negedge i_sys_clk);
		i_reset_n = 1'b1;
		@(negedge i_sys_clk);
		chk(o_rd_data, 32'h0000_0000);
		chk(o_ceiling_a_pct, 7'd10);
		t_duty();
		t_limit();
		t_accel();
		t_handoff();
		t_flags();
		t_readback();
		print_verdict();
	end
endmodule : test_open_loop_startup_config
`default_nettype wire
